//--- tdm_pdm_pkg.sv
// Shared constants, encodings and decode functions for the TDM and PDM audio serializer.
package tdm_pdm_pkg;

	// ==========================================================================
	// Field encodings
	localparam logic [1:0] SYNC_BIT = 2'h0;
	localparam logic [1:0] SYNC_SLOT = 2'h1;
	localparam logic [1:0] SYNC_HALF = 2'h2;

	localparam logic [1:0] PAD_ZERO = 2'h0;
	localparam logic [1:0] PAD_ONE = 2'h1;
	localparam logic [1:0] PAD_SIGN = 2'h2;
	localparam logic [1:0] PAD_LSB = 2'h3;

	localparam logic [1:0] SLOT_8 = 2'h0;
	localparam logic [1:0] SLOT_16 = 2'h1;
	localparam logic [1:0] SLOT_24 = 2'h2;
	localparam logic [1:0] SLOT_32 = 2'h3;

	localparam logic [2:0] WORD_8 = 3'h0;
	localparam logic [2:0] WORD_16 = 3'h1;
	localparam logic [2:0] WORD_18 = 3'h2;
	localparam logic [2:0] WORD_20 = 3'h3;
	localparam logic [2:0] WORD_24 = 3'h4;
	localparam logic [2:0] WORD_32 = 3'h5;

	// ==========================================================================
	// Reset values and counts
	localparam logic [31:0] WORD_RESET = 32'h0;
	localparam logic [5:0] BITS_RESET = 6'h0;
	localparam logic [7:0] FPOS_RESET = 8'h0;
	localparam logic [2:0] SLOT_RESET = 3'h0;
	localparam logic [5:0] PDM_HALF_LAST = 6'hf;
	localparam int unsigned DIV_WIDTH_DEFAULT = 8;

	// ==========================================================================
	// Decode functions
	function automatic logic [5:0] slot_bits(input logic [1:0] code);
		unique case (code)
			SLOT_8: slot_bits = 6'h08;
			SLOT_16: slot_bits = 6'h10;
			SLOT_24: slot_bits = 6'h18;
			SLOT_32: slot_bits = 6'h20;
		endcase
	endfunction : slot_bits

	function automatic logic [5:0] word_bits(input logic [2:0] code);
		case (code)
			WORD_8: word_bits = 6'h08;
			WORD_16: word_bits = 6'h10;
			WORD_18: word_bits = 6'h12;
			WORD_20: word_bits = 6'h14;
			WORD_24: word_bits = 6'h18;
			default: word_bits = 6'h20;
		endcase
	endfunction : word_bits

	function automatic logic pad_bit(input logic [1:0] mode, input logic sign, input logic lsb);
		unique case (mode)
			PAD_ZERO: pad_bit = 1'b0;
			PAD_ONE: pad_bit = 1'b1;
			PAD_SIGN: pad_bit = sign;
			PAD_LSB: pad_bit = lsb;
		endcase
	endfunction : pad_bit

	// Returns {in_word, word_index} for bit position b of a slot of s bits carrying a w-bit word.
	function automatic logic [5:0] slot_map(input logic [5:0] b, input logic [5:0] s,
		input logic [5:0] w, input logic right_just, input logic lsb_first);
		logic [6:0] k;
		logic ok;
		logic [6:0] idx;
		if (!right_just) begin
			k = {1'b0, b};
			ok = b < w;
		end else begin
			k = 7'({1'b0, b} + {1'b0, w} - {1'b0, s});
			ok = ({1'b0, b} + {1'b0, w}) >= {1'b0, s};
		end
		idx = lsb_first ? k : 7'({1'b0, w} - 7'h1 - k);
		slot_map = {ok, idx[4:0]};
	endfunction : slot_map

endpackage : tdm_pdm_pkg

//--- tdm_pdm_pair_buffer.sv
// Two-entry buffer with valid and ready on both sides, all outputs registered.
`timescale 1ns/1ps
`default_nettype none
module tdm_pdm_pair_buffer #(
	parameter int unsigned WIDTH = 32
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Filling side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Draining side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);

	logic [WIDTH-1:0] out_data_reg;
	logic out_valid_reg;
	logic [WIDTH-1:0] hold_data_reg;
	logic hold_valid_reg;
	logic hold_free_reg;

	// ==========================================================================
	// Head and skid entry
	// The skid entry catches a word that arrives while the head is stalled, so
	// ready can stay a flop output and still lose nothing.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			out_data_reg <= '0;
			out_valid_reg <= 1'b0;
			hold_data_reg <= '0;
			hold_valid_reg <= 1'b0;
			hold_free_reg <= 1'b1;
		end else if (out_ready || !out_valid_reg) begin
			if (hold_valid_reg) begin
				out_data_reg <= hold_data_reg;
				out_valid_reg <= 1'b1;
				hold_valid_reg <= 1'b0;
				hold_free_reg <= 1'b1;
			end else begin
				out_valid_reg <= in_valid;
				if (in_valid) begin
					out_data_reg <= in_data;
				end
			end
		end else if (in_valid && !hold_valid_reg) begin
			hold_data_reg <= in_data;
			hold_valid_reg <= 1'b1;
			hold_free_reg <= 1'b0;
		end
	end

	// Ready has its own flop so the port carries no inverter behind the register.
	assign in_ready = hold_free_reg;
	assign out_data = out_data_reg;
	assign out_valid = out_valid_reg;

endmodule : tdm_pdm_pair_buffer
`default_nettype wire

//--- tdm_pdm_audio_serializer.sv
// TDM and PDM serial audio controller: clock divider, frame timing, serializers, PDM packing.
//
// Notes on behaviour
// - Data leaves on serial clock falling edge, is sampled on rising edge.
// - Frame sync is asserted to mark the start of slot 0.
// - First data bit starts at sync transition or one serial clock later.
// - Sync pulse lasts one bit, one slot or half the frame.
// - Slot count sets the number of slots per frame.
// - Slot width sets the number of serial clock bits per slot.
// - Word length is 8, 16, 18, 20, 24 or 32, per direction.
// - Word sits left- or right-justified within its slot.
// - Bit order is MSB first or LSB first, per direction.
// - Slot bits beyond the word are filled per the padding select.
// - Short slot drops extra transmit bits and extends received words by padding.
// - PDM reception samples one bit on every serial clock rising edge.
// - Single PDM microphone packs word-length consecutive samples per word.
// - Dual PDM packs sixteen left samples low and sixteen right samples high.
// - PDM mode uses only serial clock and data input; frame sync idle.
// - Serial clock is the input clock divided by twice (master clock divider + 1).
`timescale 1ns/1ps
`default_nettype none
module tdm_pdm_audio_serializer
	import tdm_pdm_pkg::*;
#(
	parameter int unsigned DIV_WIDTH = DIV_WIDTH_DEFAULT
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Clock unit control
	input wire logic enable,
	input wire logic pdm_mode,
	input wire logic dual_microphone_mode,
	input wire logic [DIV_WIDTH-1:0] master_clock_divider,
	input wire logic [2:0] slot_count,
	input wire logic [1:0] slot_width,
	input wire logic first_bit_delay,
	input wire logic [1:0] sync_pulse_width,
	// Transmit serializer control
	input wire logic [2:0] tx_word_length,
	input wire logic tx_right_justify,
	input wire logic tx_lsb_first,
	input wire logic [1:0] tx_padding,
	// Receive serializer control
	input wire logic [2:0] rx_word_length,
	input wire logic rx_right_justify,
	input wire logic rx_lsb_first,
	input wire logic [1:0] rx_padding,
	// Transmit word stream
	input wire logic [31:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// Receive word stream
	output logic [31:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	// Status pulses
	output logic tx_underrun,
	output logic rx_overrun,
	// Pins
	output logic serial_clock_pin,
	output logic frame_sync_pin,
	output logic serial_data_line,
	output logic serial_data_line_oe,
	input wire logic serial_data_input
);

	// ==========================================================================
	// Input synchroniser
	logic sdi_meta_reg;
	logic sdi_sync_reg;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			sdi_meta_reg <= 1'b0;
			sdi_sync_reg <= 1'b0;
		end else begin
			sdi_meta_reg <= serial_data_input;
			sdi_sync_reg <= sdi_meta_reg;
		end
	end

	// ==========================================================================
	// Serial clock divider
	// Each half period lasts divider+1 input clocks; the two-flop input path
	// needs a divider of at least 2 so a sample lands in its own bit.
	logic [DIV_WIDTH-1:0] div_cnt_reg;
	logic sck_reg;
	logic toggle_ev;
	logic rise_ev;
	logic fall_ev;
	logic tdm_run;
	logic pdm_run;

	assign tdm_run = enable && !pdm_mode;
	assign pdm_run = enable && pdm_mode;
	assign toggle_ev = enable && (div_cnt_reg == master_clock_divider);
	assign rise_ev = toggle_ev && !sck_reg;
	assign fall_ev = toggle_ev && sck_reg;

	always_ff @(posedge clock) begin
		if (!rstn || !enable) begin
			div_cnt_reg <= '0;
			sck_reg <= 1'b0;
		end else if (toggle_ev) begin
			div_cnt_reg <= '0;
			sck_reg <= !sck_reg;
		end else begin
			div_cnt_reg <= div_cnt_reg + 1'b1;
		end
	end

	// ==========================================================================
	// Frame geometry and position
	logic [5:0] slot_len;
	logic [5:0] slot_last;
	logic [8:0] frame_len;
	logic [7:0] frame_last;
	logic [5:0] bit_cnt_reg;
	logic [2:0] slot_cnt_reg;
	logic [7:0] fpos_reg;
	logic started_reg;
	logic bit_wrap;
	logic frame_wrap;
	logic [5:0] bit_next;
	logic [2:0] slot_next;
	logic [7:0] fpos_next;
	logic [7:0] sync_pos;
	logic sync_next;

	assign slot_len = slot_bits(slot_width);
	assign slot_last = slot_len - 6'h1;
	assign frame_len = 9'(({6'h0, slot_count} + 9'h1) * {3'h0, slot_len});
	assign frame_last = 8'(frame_len - 9'h1);
	assign bit_wrap = bit_cnt_reg >= slot_last;
	assign frame_wrap = bit_wrap && (slot_cnt_reg >= slot_count);

	always_comb begin
		if (!started_reg) begin
			bit_next = BITS_RESET;
			slot_next = SLOT_RESET;
			fpos_next = FPOS_RESET;
		end else begin
			bit_next = bit_wrap ? BITS_RESET : bit_cnt_reg + 6'h1;
			slot_next = frame_wrap ? SLOT_RESET : (bit_wrap ? slot_cnt_reg + 3'h1 : slot_cnt_reg);
			fpos_next = frame_wrap ? FPOS_RESET : fpos_reg + 8'h1;
		end
	end

	// With the delay on, sync runs one bit ahead of the data it frames.
	assign sync_pos = (first_bit_delay && fpos_next >= frame_last) ? FPOS_RESET :
		(first_bit_delay ? fpos_next + 8'h1 : fpos_next);

	always_comb begin
		unique case (sync_pulse_width)
			SYNC_SLOT: sync_next = sync_pos < {2'h0, slot_len};
			SYNC_HALF: sync_next = sync_pos < frame_len[8:1];
			default: sync_next = sync_pos == FPOS_RESET;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn || !tdm_run) begin
			bit_cnt_reg <= BITS_RESET;
			slot_cnt_reg <= SLOT_RESET;
			fpos_reg <= FPOS_RESET;
			started_reg <= 1'b0;
		end else if (fall_ev) begin
			bit_cnt_reg <= bit_next;
			slot_cnt_reg <= slot_next;
			fpos_reg <= fpos_next;
			started_reg <= 1'b1;
		end
	end

	// ==========================================================================
	// Transmit serializer
	logic [31:0] txb_data;
	logic txb_valid;
	logic txb_take;
	logic [31:0] tx_word_reg;
	logic [31:0] tx_cur;
	logic [5:0] tx_w;
	logic [5:0] tx_map;
	logic tx_bit;
	logic sd_reg;
	logic fs_reg;
	logic oe_reg;
	logic underrun_reg;

	assign txb_take = tdm_run && fall_ev && (bit_next == BITS_RESET);

	tdm_pdm_pair_buffer #(.WIDTH(32)) tx_buffer (
		.clock(clock),
		.rstn(rstn),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.out_data(txb_data),
		.out_valid(txb_valid),
		.out_ready(txb_take)
	);

	assign tx_w = word_bits(tx_word_length);
	assign tx_cur = (bit_next == BITS_RESET) ? (txb_valid ? txb_data : WORD_RESET) : tx_word_reg;
	assign tx_map = slot_map(bit_next, slot_len, tx_w, tx_right_justify, tx_lsb_first);
	// Out-of-word positions carry padding, and a short slot simply never reaches the excess bits.
	assign tx_bit = tx_map[5] ? tx_cur[tx_map[4:0]] :
		pad_bit(tx_padding, tx_cur[5'(tx_w - 6'h1)], tx_cur[0]);

	always_ff @(posedge clock) begin
		if (!rstn || !tdm_run) begin
			tx_word_reg <= WORD_RESET;
			sd_reg <= 1'b0;
			fs_reg <= 1'b0;
		end else if (fall_ev) begin
			if (bit_next == BITS_RESET) begin
				tx_word_reg <= tx_cur;
			end
			sd_reg <= tx_bit;
			fs_reg <= sync_next;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			oe_reg <= 1'b0;
			underrun_reg <= 1'b0;
		end else begin
			oe_reg <= tdm_run;
			underrun_reg <= txb_take && !txb_valid;
		end
	end

	// ==========================================================================
	// Receive serializer
	logic [5:0] rx_w;
	logic [5:0] rx_map;
	logic [31:0] rx_acc_reg;
	logic [31:0] rx_got_reg;
	logic [31:0] rx_acc_n;
	logic [31:0] rx_got_n;
	logic [31:0] rx_final;
	logic rx_sample;
	logic rx_tdm_done;
	logic rx_pad;

	assign rx_w = word_bits(rx_word_length);
	assign rx_map = slot_map(bit_cnt_reg, slot_len, rx_w, rx_right_justify, rx_lsb_first);
	assign rx_sample = tdm_run && rise_ev && started_reg;
	assign rx_tdm_done = rx_sample && bit_wrap;

	always_comb begin
		rx_acc_n = rx_acc_reg;
		rx_got_n = rx_got_reg;
		if (rx_map[5]) begin
			rx_acc_n[rx_map[4:0]] = sdi_sync_reg;
			rx_got_n[rx_map[4:0]] = 1'b1;
		end
	end

	assign rx_pad = pad_bit(rx_padding, rx_acc_n[5'(rx_w - 6'h1)], rx_acc_n[0]);

	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_extend
			assign rx_final[gi] = rx_got_n[gi] ? rx_acc_n[gi] : rx_pad;
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (!rstn || !tdm_run || rx_tdm_done) begin
			rx_acc_reg <= WORD_RESET;
			rx_got_reg <= WORD_RESET;
		end else if (rx_sample) begin
			rx_acc_reg <= rx_acc_n;
			rx_got_reg <= rx_got_n;
		end
	end

	// ==========================================================================
	// PDM reception
	// Samples enter at bit 0 and shift up, so the oldest sample ends highest.
	logic [31:0] pdm_lo_reg;
	logic [15:0] pdm_hi_reg;
	logic [5:0] pdm_cnt_reg;
	logic [31:0] pdm_lo_n;
	logic [31:0] pdm_mask;
	logic pdm_single_done;
	logic pdm_dual_done;

	assign pdm_lo_n = {pdm_lo_reg[30:0], sdi_sync_reg};
	assign pdm_mask = (rx_w >= 6'h20) ? 32'hffffffff : ((32'h1 << rx_w) - 32'h1);
	assign pdm_single_done = pdm_run && !dual_microphone_mode && rise_ev &&
		(pdm_cnt_reg >= rx_w - 6'h1);
	assign pdm_dual_done = pdm_run && dual_microphone_mode && fall_ev &&
		(pdm_cnt_reg >= PDM_HALF_LAST);

	always_ff @(posedge clock) begin
		if (!rstn || !pdm_run) begin
			pdm_lo_reg <= WORD_RESET;
			pdm_hi_reg <= 16'h0;
			pdm_cnt_reg <= BITS_RESET;
		end else begin
			if (rise_ev) begin
				pdm_lo_reg <= pdm_lo_n;
			end
			if (fall_ev && dual_microphone_mode) begin
				pdm_hi_reg <= {pdm_hi_reg[14:0], sdi_sync_reg};
			end
			if (pdm_single_done || pdm_dual_done) begin
				pdm_cnt_reg <= BITS_RESET;
			end else if ((rise_ev && !dual_microphone_mode) || (fall_ev && dual_microphone_mode)) begin
				pdm_cnt_reg <= pdm_cnt_reg + 6'h1;
			end
		end
	end

	// ==========================================================================
	// Receive buffer
	logic rxb_push;
	logic rxb_ready;
	logic [31:0] rxb_word;
	logic overrun_reg;

	assign rxb_push = rx_tdm_done || pdm_single_done || pdm_dual_done;
	assign rxb_word = pdm_dual_done ? {pdm_hi_reg[14:0], sdi_sync_reg, pdm_lo_reg[15:0]} :
		(pdm_single_done ? (pdm_lo_n & pdm_mask) : rx_final);

	tdm_pdm_pair_buffer #(.WIDTH(32)) rx_buffer (
		.clock(clock),
		.rstn(rstn),
		.in_data(rxb_word),
		.in_valid(rxb_push),
		.in_ready(rxb_ready),
		.out_data(rx_data),
		.out_valid(rx_valid),
		.out_ready(rx_ready)
	);

	always_ff @(posedge clock) begin
		if (!rstn) begin
			overrun_reg <= 1'b0;
		end else begin
			overrun_reg <= rxb_push && !rxb_ready;
		end
	end

	assign serial_clock_pin = sck_reg;
	assign frame_sync_pin = fs_reg;
	assign serial_data_line = sd_reg;
	assign serial_data_line_oe = oe_reg;
	assign tx_underrun = underrun_reg;
	assign rx_overrun = overrun_reg;

	// ==========================================================================
	// Assertions
	a_launch_on_fall: assert property (@(posedge clock) disable iff (!rstn)
		(tdm_run && $past(tdm_run) && $changed(serial_data_line)) |-> $fell(serial_clock_pin))
		else $error("serial data changed away from a falling serial clock");

	a_sample_on_rise: assert property (@(posedge clock) disable iff (!rstn)
		(pdm_run && rise_ev) |=> (serial_clock_pin && pdm_lo_reg[0] == $past(sdi_sync_reg)))
		else $error("pdm sample not taken at the rising serial clock");

	a_sync_slot_zero: assert property (@(posedge clock) disable iff (!rstn)
		(tdm_run && !first_bit_delay && $rose(frame_sync_pin)) |-> (fpos_reg == FPOS_RESET))
		else $error("frame sync rose away from slot zero");

	a_sync_delayed: assert property (@(posedge clock) disable iff (!rstn)
		(tdm_run && first_bit_delay && $past(started_reg) && $rose(frame_sync_pin))
		|-> (fpos_reg == frame_last))
		else $error("delayed frame sync not one bit ahead of frame");

	a_sync_slot_width: assert property (@(posedge clock) disable iff (!rstn)
		(tdm_run && !first_bit_delay && sync_pulse_width == SYNC_SLOT && frame_sync_pin)
		|-> (fpos_reg < {2'h0, slot_len}))
		else $error("slot-wide frame sync outside slot zero");

	a_slot_wrap: assert property (@(posedge clock) disable iff (!rstn)
		(tdm_run && fall_ev && started_reg && bit_wrap && slot_cnt_reg >= slot_count)
		|=> (slot_cnt_reg == SLOT_RESET && bit_cnt_reg == BITS_RESET))
		else $error("frame did not close after the last slot");

	a_bit_wrap: assert property (@(posedge clock) disable iff (!rstn)
		(tdm_run && fall_ev && started_reg && bit_cnt_reg == slot_last) |=> (bit_cnt_reg == BITS_RESET))
		else $error("slot did not end after slot width bits");

	a_no_idle: assert property (@(posedge clock) disable iff (!rstn)
		(tdm_run && fall_ev && started_reg && fpos_reg == frame_last) |=> (fpos_reg == FPOS_RESET))
		else $error("idle bit inserted between frames");

	a_pdm_pins: assert property (@(posedge clock) disable iff (!rstn)
		pdm_run [*2] |-> (!frame_sync_pin && !serial_data_line_oe))
		else $error("frame sync or data out active in pdm mode");

	a_divider_rate: assert property (@(posedge clock) disable iff (!rstn)
		(enable && $past(enable) && $changed(serial_clock_pin)) |-> ($past(div_cnt_reg) == master_clock_divider))
		else $error("serial clock edge off the divider count");

	a_dual_push: assert property (@(posedge clock) disable iff (!rstn)
		(pdm_run && dual_microphone_mode && rxb_push) |-> (fall_ev && pdm_cnt_reg == PDM_HALF_LAST))
		else $error("dual microphone word not after sixteen sample pairs");

endmodule : tdm_pdm_audio_serializer
`default_nettype wire

//--- audio_far_side.sv
// Far-side model: a codec that echoes the data line, or one or two PDM microphones.
`timescale 1ns/1ps
`default_nettype none
module audio_far_side (
	// Mode
	input wire logic pdm_on,
	// Pins
	input wire logic serial_clock_pin,
	input wire logic serial_data_line,
	input wire logic serial_data_line_oe,
	output logic serial_data_input
);
	// ==========================================================================
	// Microphones and codec
	// In PDM the left microphone shows a one for each rising edge and the right one a zero
	// for each falling edge. In TDM the codec echoes the line, and a released line shows
	// the inverse of its last level, so stale data never passes.
	always @(serial_clock_pin, serial_data_line, serial_data_line_oe, pdm_on) begin
		if (pdm_on) begin
			serial_data_input <= !serial_clock_pin;
		end else if (serial_data_line_oe) begin
			serial_data_input <= serial_data_line;
		end else begin
			serial_data_input <= ~serial_data_input;
		end
	end
endmodule : audio_far_side
`default_nettype wire

//--- test_tdm_pdm_audio_serializer.sv
// Self-checking testbench for the TDM and PDM audio serializer.
`timescale 1ns/1ps
`default_nettype none
module test_tdm_pdm_audio_serializer
	import tdm_pdm_pkg::*;
;
	// ==========================================================================
	// Signals
	typedef struct {
		logic [1:0] sw;
		logic [2:0] twl;
		logic [2:0] rwl;
		logic [3:0] f;
		logic [1:0] tp;
		logic [1:0] rp;
		logic [31:0] d;
		logic [31:0] e;
	} row_t;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic enable = 1'b0, pdm_mode = 1'b0, dual_microphone_mode = 1'b0;
	logic [7:0] master_clock_divider = 8'h02;
	logic [2:0] slot_count = 3'h0, tx_word_length = 3'h5, rx_word_length = 3'h5;
	logic [1:0] slot_width = 2'h3, sync_pulse_width = 2'h0, tx_padding = 2'h0, rx_padding = 2'h0;
	logic first_bit_delay = 1'b0, tx_right_justify = 1'b0, tx_lsb_first = 1'b0;
	logic rx_right_justify = 1'b0, rx_lsb_first = 1'b0, tx_valid = 1'b0, rx_ready = 1'b1;
	logic [31:0] tx_data = 32'h0;
	logic [31:0] rx_data;
	logic tx_ready, rx_valid, tx_underrun, rx_overrun, serial_clock_pin, frame_sync_pin;
	logic serial_data_line, serial_data_line_oe, serial_data_input;
	logic und_seen = 1'b0, ovr_seen = 1'b0;
	int mismatches = 0, n_compared = 0;
	// Flags {tx right, rx right, tx lsb first, rx lsb first}; one slot per frame.
	row_t rows [9] = '{
		'{SLOT_32, WORD_32, WORD_32, 4'h0, PAD_ZERO, PAD_ZERO, 32'h12345678, 32'h12345678},
		'{SLOT_32, WORD_32, WORD_32, 4'h1, PAD_ZERO, PAD_ZERO, 32'h12345678, 32'h1e6a2c48},
		'{SLOT_16, WORD_16, WORD_16, 4'h3, PAD_ZERO, PAD_ONE, 32'h0000a5c3, 32'hffffa5c3},
		'{SLOT_32, WORD_8, WORD_8, 4'h0, PAD_ZERO, PAD_SIGN, 32'h00000096, 32'hffffff96},
		'{SLOT_32, WORD_24, WORD_24, 4'hc, PAD_ZERO, PAD_LSB, 32'h00abcdef, 32'hffabcdef},
		'{SLOT_32, WORD_24, WORD_24, 4'h4, PAD_ONE, PAD_ZERO, 32'h00abcdef, 32'h00cdefff},
		'{SLOT_8, WORD_16, WORD_16, 4'h0, PAD_ZERO, PAD_ZERO, 32'h0000beef, 32'h0000be00},
		'{SLOT_24, WORD_20, WORD_20, 4'h0, PAD_ZERO, PAD_SIGN, 32'h000fabcd, 32'hffffabcd},
		'{SLOT_24, WORD_18, WORD_18, 4'h0, PAD_ZERO, PAD_ONE, 32'h0002aaaa, 32'hfffeaaaa}};

	tdm_pdm_audio_serializer #(.DIV_WIDTH(8)) tdm_pdm_audio_serializer_i (.clock, .rstn,
		.enable, .pdm_mode, .dual_microphone_mode, .master_clock_divider, .slot_count,
		.slot_width, .first_bit_delay, .sync_pulse_width, .tx_word_length, .tx_right_justify,
		.tx_lsb_first, .tx_padding, .rx_word_length, .rx_right_justify, .rx_lsb_first,
		.rx_padding, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready,
		.tx_underrun, .rx_overrun, .serial_clock_pin, .frame_sync_pin, .serial_data_line,
		.serial_data_line_oe, .serial_data_input);
	audio_far_side audio_far_side_i (.pdm_on(pdm_mode), .serial_clock_pin, .serial_data_line,
		.serial_data_line_oe, .serial_data_input);

	always #20 clock = ~clock;
	// Status pulses last one cycle, so they are caught in sticky flags.
	always @(posedge clock) begin
		if (!rstn) begin
			und_seen <= 1'b0;
			ovr_seen <= 1'b0;
		end else begin
			if (tx_underrun === 1'b1) und_seen <= 1'b1;
			if (rx_overrun === 1'b1) ovr_seen <= 1'b1;
		end
	end

	// ==========================================================================
	// Tasks
	task automatic results();
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : results
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic stop();
		@(posedge clock);
		tx_valid <= 1'b0;
		enable <= 1'b0;
		@(posedge clock);
	endtask : stop
	// Configuration is set by the caller in the same step, while the block is stopped.
	task automatic go(input logic [31:0] d);
		tx_data <= d;
		tx_valid <= 1'b1;
		@(posedge clock);
		enable <= 1'b1;
	endtask : go
	task automatic get(input int n, output logic [31:0] w);
		int k;
		k = 0;
		w = 32'h0;
		repeat (20000) begin
			@(posedge clock);
			if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
				w = rx_data;
				k++;
				if (k == n) break;
			end
		end
		if (k < n) begin
			mismatches++;
			results();
		end
	endtask : get
	// Measures one frame: sync width and period in clocks, data level at the sync rise.
	task automatic frame(output int w, output int p, output logic fb);
		int ph;
		logic prev;
		ph = 1;
		prev = 1'b1;
		w = 0;
		p = 0;
		fb = 1'b0;
		repeat (3000) begin
			@(posedge clock);
			if (ph == 2 && frame_sync_pin === 1'b1 && !prev) ph = 3;
			if (ph == 1 && frame_sync_pin === 1'b1 && !prev) begin
				ph = 2;
				fb = serial_data_line;
			end
			if (ph == 2) begin
				p++;
				w += int'(frame_sync_pin);
			end
			if (ph == 3) break;
			prev = frame_sync_pin;
		end
		if (ph != 3) begin
			mismatches++;
			results();
		end
	endtask : frame

	// ==========================================================================
	// Sequence
	initial begin
		logic [31:0] w;
		int wd;
		int pd;
		int n;
		logic fb;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			stop();
			slot_width <= rows[i].sw;
			tx_word_length <= rows[i].twl;
			rx_word_length <= rows[i].rwl;
			{tx_right_justify, rx_right_justify, tx_lsb_first, rx_lsb_first} <= rows[i].f;
			tx_padding <= rows[i].tp;
			rx_padding <= rows[i].rp;
			go(rows[i].d);
			get(5, w);
			check("row word", w, rows[i].e);
		end
		// Four slots of eight bits, six clocks per bit: 192 clocks a frame.
		for (int c = 0; c < 4; c++) begin
			stop();
			slot_count <= 3'h3;
			slot_width <= SLOT_8;
			tx_word_length <= WORD_32;
			sync_pulse_width <= 2'(c);
			go(32'h80000000);
			frame(wd, pd, fb);
			frame(wd, pd, fb);
			check("sync width", 32'(wd), c == 1 ? 32'h30 : c == 2 ? 32'h60 : 32'h6);
			check("frame period", 32'(pd), 32'hc0);
			check("first bit", 32'(fb), 32'h1);
		end
		stop();
		first_bit_delay <= 1'b1;
		sync_pulse_width <= SYNC_BIT;
		master_clock_divider <= 8'h03;
		go(32'h80000000);
		frame(wd, pd, fb);
		frame(wd, pd, fb);
		check("slow period", 32'(pd), 32'h100);
		check("delayed bit", 32'(fb), 32'h0);
		stop();
		pdm_mode <= 1'b1;
		dual_microphone_mode <= 1'b1;
		first_bit_delay <= 1'b0;
		slot_count <= 3'h0;
		master_clock_divider <= 8'h02;
		{rx_right_justify, rx_lsb_first, rx_padding} <= 4'h0;
		go(32'h0);
		get(3, w);
		check("dual word", w, 32'h0000ffff);
		check("pdm pins", {30'h0, frame_sync_pin, serial_data_line_oe}, 32'h0);
		stop();
		dual_microphone_mode <= 1'b0;
		rx_word_length <= WORD_16;
		go(32'h0);
		get(3, w);
		check("single 16", w, 32'h0000ffff);
		stop();
		rx_word_length <= WORD_32;
		go(32'h0);
		get(3, w);
		check("single 32", w, 32'hffffffff);
		// A reset in mid-run returns every output to idle with the buffer empty.
		rstn <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		check("reset outs", {25'h0, serial_clock_pin, frame_sync_pin, serial_data_line_oe,
			rx_valid, tx_ready, rx_overrun, tx_underrun}, 32'h4);
		@(posedge clock);
		rstn <= 1'b1;
		enable <= 1'b0;
		pdm_mode <= 1'b0;
		slot_width <= SLOT_32;
		rx_ready <= 1'b0;
		tx_data <= 32'hc0ffee01;
		tx_valid <= 1'b1;
		n = 0;
		repeat (30) begin
			@(posedge clock);
			if (tx_ready === 1'b1) begin
				n++;
				tx_data <= n == 1 ? 32'h5a5a0f0f : 32'h77777777;
			end
		end
		tx_valid <= 1'b0;
		check("accepted", 32'(n), 32'h2);
		enable <= 1'b1;
		repeat (3000) begin
			@(posedge clock);
			if (ovr_seen) break;
		end
		if (ovr_seen !== 1'b1) begin
			mismatches++;
			results();
		end
		check("status", {30'h0, und_seen, ovr_seen}, 32'h3);
		rx_ready <= 1'b1;
		get(1, w);
		check("first word", w, 32'hc0ffee01);
		get(1, w);
		check("second word", w, 32'h5a5a0f0f);
		get(1, w);
		check("starved word", w, 32'h0);
		results();
	end
endmodule : test_tdm_pdm_audio_serializer
`default_nettype wire
